// File: rtl/dbs_pkg.sv
// Shared constants and types for the burst sequencer.
`default_nettype none
package dbs_pkg;
    localparam int DBS_DQ_W = 16;
    localparam int DBS_BANK_W = 2;
    localparam int DBS_COL_W = 4;
    localparam int DBS_ADDR_W = 13;
    localparam int DBS_AP_BIT = 10;
    localparam int DBS_FIFO_DEPTH = 16;
    localparam int DBS_NBANK = 4;

    // Command code is {cs_n, ras_n, cas_n, we_n}.
    localparam logic [3:0] DBS_CMD_NOP = 4'h7;
    localparam logic [3:0] DBS_CMD_ACT = 4'h3;
    localparam logic [3:0] DBS_CMD_READ = 4'h5;
    localparam logic [3:0] DBS_CMD_WRITE = 4'h4;
    localparam logic [3:0] DBS_CMD_BST = 4'h6;
    localparam logic [3:0] DBS_CMD_PRE = 4'h2;

    // Read latency select codes.
    localparam logic [1:0] DBS_CL_2 = 2'h0;
    localparam logic [1:0] DBS_CL_2P5 = 2'h1;
    localparam logic [1:0] DBS_CL_3 = 2'h2;

    // Burst length codes are log2 of the element count.
    localparam logic [1:0] DBS_BL_2 = 2'h1;
    localparam logic [1:0] DBS_BL_4 = 2'h2;
    localparam logic [1:0] DBS_BL_8 = 2'h3;

    localparam logic [1:0] DBS_CL_RST = DBS_CL_2;
    localparam logic [1:0] DBS_BL_RST = DBS_BL_4;
    localparam logic DBS_ITL_RST = 1'b0;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } dbs_cmd_t;

    typedef struct packed {
        logic [DBS_BANK_W-1:0] bank;
        logic [DBS_COL_W-1:0] col;
        logic [DBS_DQ_W-1:0] data;
    } dbs_wlog_t;

    typedef struct packed {
        logic [1:0] cl;
        logic [1:0] bl;
        logic itl;
    } dbs_cfg_t;
endpackage
`default_nettype wire

// File: rtl/dbs_ddr_sequencer.sv
// Burst sequencer of a double data rate DRAM with its write log FIFO.
//
// Contract
// - Read latency selectable as 2, 2.5 or 3.
// - Remaining read elements follow in burst order.
// - Burst-spaced reads concatenate at 4, cut at 8.
// - New read truncates an ongoing read burst.
// - Burst terminate command stops read data early.
// - Low auto_precharge_bit write leaves the row open.
// - New write truncates an ongoing write burst.
// - Read interrupting a write keeps only taken elements.
`default_nettype none

module dbs_async_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic wclk,
    input wire logic wrst_b,
    input wire logic wen,
    input wire logic w_valid,
    output logic w_ready,
    input wire logic [WIDTH-1:0] w_data,
    input wire logic rclk,
    input wire logic rrst_b,
    input wire logic ren,
    output logic r_valid,
    input wire logic r_ready,
    output logic [WIDTH-1:0] r_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW:0] wbin, wgray, rbin, rgray;
    logic [AW:0] rg_q1, rg_q2, wg_q1, wg_q2;
    logic [AW:0] next_wbin, next_rbin;
    logic full, empty, push, pop;

    assign next_wbin = wbin + 1'b1;
    assign next_rbin = rbin + 1'b1;
    assign full = wgray == {~rg_q2[AW:AW-1], rg_q2[AW-2:0]};
    assign empty = rgray == wg_q2;
    assign w_ready = !full;
    assign push = wen && w_valid && !full;
    assign pop = ren && !empty && (!r_valid || r_ready);

    always_ff @(posedge wclk) begin
        if (push) begin
            store[wbin[AW-1:0]] <= w_data;
        end
    end

    always_ff @(posedge wclk) begin
        if (!wrst_b) begin
            wbin <= '0;
            wgray <= '0;
        end else if (push) begin
            wbin <= next_wbin;
            wgray <= next_wbin ^ (next_wbin >> 1);
        end
    end

    always_ff @(posedge wclk) begin
        if (!wrst_b) begin
            rg_q1 <= '0;
            rg_q2 <= '0;
        end else begin
            rg_q1 <= rgray;
            rg_q2 <= rg_q1;
        end
    end

    always_ff @(posedge rclk) begin
        if (!rrst_b) begin
            wg_q1 <= '0;
            wg_q2 <= '0;
        end else begin
            wg_q1 <= wgray;
            wg_q2 <= wg_q1;
        end
    end

    always_ff @(posedge rclk) begin
        if (!rrst_b) begin
            rbin <= '0;
            rgray <= '0;
            r_valid <= 1'b0;
            r_data <= '0;
        end else if (ren) begin
            if (pop) begin
                rbin <= next_rbin;
                rgray <= next_rbin ^ (next_rbin >> 1);
                r_data <= store[rbin[AW-1:0]];
                r_valid <= 1'b1;
            end else if (r_ready) begin
                r_valid <= 1'b0;
            end
        end
    end
endmodule // dbs_async_fifo

module dbs_ddr_sequencer import dbs_pkg::*; #(
    parameter int FIFO_DEPTH = DBS_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [1:0] cfg_cas_latency,
    input wire logic [1:0] cfg_burst_length,
    input wire logic cfg_interleave,
    input wire logic link_ck,
    input wire dbs_cmd_t link_cmd,
    input wire logic [DBS_BANK_W-1:0] link_bank,
    input wire logic [DBS_ADDR_W-1:0] link_addr,
    input wire logic [DBS_DQ_W-1:0] dq_in,
    output logic [DBS_DQ_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic dqs_in,
    output logic dqs_out,
    output logic dqs_oe,
    output logic wlog_valid,
    input wire logic wlog_ready,
    output dbs_wlog_t wlog_data,
    output logic [DBS_NBANK-1:0] bank_open_sts,
    output logic link_busy
);
    localparam int MW = DBS_BANK_W + DBS_COL_W;
    localparam int CPAD = DBS_COL_W - 3;

    dbs_cfg_t cfg, cfg_q1, cfg_q2;
    logic rst_q1, link_rst_b, en_q1, link_en;
    logic [DBS_NBANK-1:0] open_q1, open_q2;
    logic busy_q1;

    logic is_read, is_write, is_bst, is_act, is_pre;
    logic [3:0] bl_len;
    logic [2:0] mask;
    logic half;

    logic [DBS_DQ_W-1:0] mem [0:(1<<MW)-1];
    logic [2:0] pv, ps, pa;
    logic [DBS_BANK_W-1:0] pb [0:2];
    logic [DBS_COL_W-1:0] pc [0:2];
    logic tap_v, tap_s, tap_a;
    logic [DBS_BANK_W-1:0] tap_b;
    logic [DBS_COL_W-1:0] tap_c;

    logic rd_oe, rd_run, rd_ap, dqs_q, rd_done;
    logic [2:0] rd_idx;
    logic [DBS_BANK_W-1:0] rd_bank;
    logic [DBS_COL_W-1:0] rd_col;
    logic [DBS_DQ_W-1:0] dq_q, dq_n;
    logic oe_n, dqs_n;

    logic wr_active, wr_ap, dqs_prev, wr_take, wr_done, fifo_ready;
    logic [2:0] wr_idx;
    logic [DBS_BANK_W-1:0] wr_bank;
    logic [DBS_COL_W-1:0] wr_col, wcol;
    logic [DBS_NBANK-1:0] bank_open, next_open;
    dbs_wlog_t push_data;

    function automatic logic [DBS_COL_W-1:0] elem_col(
        input logic [DBS_COL_W-1:0] start,
        input logic [2:0] idx,
        input logic [2:0] msk,
        input logic itl
    );
        logic [2:0] low;
        low = itl ? (start[2:0] ^ idx) : 3'(start[2:0] + idx);
        return (start & ~{{CPAD{1'b0}}, msk}) | {{CPAD{1'b0}}, low & msk};
    endfunction

    // Core side configuration, frozen while the clock enable is low.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cfg <= '{cl: DBS_CL_RST, bl: DBS_BL_RST, itl: DBS_ITL_RST};
        end else if (clk_en) begin
            cfg <= '{cl: cfg_cas_latency, bl: cfg_burst_length,
                     itl: cfg_interleave};
        end
    end

    // Reset, enable and configuration enter the link domain.
    always_ff @(posedge link_ck) begin
        rst_q1 <= rst_b;
        link_rst_b <= rst_q1;
        en_q1 <= clk_en;
        link_en <= en_q1;
        cfg_q1 <= cfg;
        cfg_q2 <= cfg_q1;
    end

    assign bl_len = 4'h1 << cfg_q2.bl;
    assign mask = 3'(bl_len - 4'h1);
    assign half = cfg_q2.cl == DBS_CL_2P5;
    assign is_read = link_en && link_cmd == DBS_CMD_READ;
    assign is_write = link_en && link_cmd == DBS_CMD_WRITE;
    assign is_bst = link_en && link_cmd == DBS_CMD_BST;
    assign is_act = link_en && link_cmd == DBS_CMD_ACT;
    assign is_pre = link_en && link_cmd == DBS_CMD_PRE;

    // Read and terminate commands travel down a latency pipeline.
    always_ff @(posedge link_ck) begin
        if (!link_rst_b) begin
            pv <= '0;
            ps <= '0;
            pa <= '0;
        end else if (link_en) begin
            pv <= {pv[1:0], is_read};
            ps <= {ps[1:0], is_bst};
            pa <= {pa[1:0], link_addr[DBS_AP_BIT]};
        end
    end

    generate
        for (genvar s = 0; s < 3; s++) begin : g_pipe
            always_ff @(posedge link_ck) begin
                if (link_en) begin
                    pb[s] <= (s == 0) ? link_bank : pb[(s == 0) ? 0 : s - 1];
                    pc[s] <= (s == 0) ? link_addr[DBS_COL_W-1:0]
                                      : pc[(s == 0) ? 0 : s - 1];
                end
            end
        end
    endgenerate

    always_comb begin
        if (cfg_q2.cl == DBS_CL_3) begin
            tap_v = pv[2];
            tap_s = ps[2];
            tap_a = pa[2];
            tap_b = pb[2];
            tap_c = pc[2];
        end else begin
            tap_v = pv[1];
            tap_s = ps[1];
            tap_a = pa[1];
            tap_b = pb[1];
            tap_c = pc[1];
        end
    end

    assign rd_done = rd_run && rd_idx == mask && !tap_v && !tap_s;

    // Read burst engine; a newly arrived read start always wins.
    always_ff @(posedge link_ck) begin
        if (!link_rst_b) begin
            rd_oe <= 1'b0;
            rd_run <= 1'b0;
            rd_ap <= 1'b0;
            rd_idx <= '0;
            rd_bank <= '0;
            rd_col <= '0;
            dq_q <= '0;
            dqs_q <= 1'b0;
        end else if (link_en) begin
            if (tap_v) begin
                dq_q <= mem[{tap_b, elem_col(tap_c, 3'h0, mask, cfg_q2.itl)}];
                dqs_q <= ~dqs_q;
                rd_oe <= 1'b1;
                rd_run <= 1'b1;
                rd_idx <= 3'h1;
                rd_bank <= tap_b;
                rd_col <= tap_c;
                rd_ap <= tap_a;
            end else if (tap_s) begin
                rd_oe <= 1'b0;
                rd_run <= 1'b0;
                dqs_q <= 1'b0;
            end else if (rd_run) begin
                dq_q <= mem[{rd_bank, elem_col(rd_col, rd_idx, mask,
                                               cfg_q2.itl)}];
                dqs_q <= ~dqs_q;
                rd_idx <= rd_idx + 3'h1;
                rd_run <= rd_idx != mask;
            end else begin
                rd_oe <= 1'b0;
                dqs_q <= 1'b0;
            end
        end
    end

    // The half cycle latency re-times the output on the falling edge.
    always_ff @(negedge link_ck) begin
        if (!link_rst_b) begin
            dq_n <= '0;
            oe_n <= 1'b0;
            dqs_n <= 1'b0;
        end else begin
            dq_n <= dq_q;
            oe_n <= rd_oe;
            dqs_n <= dqs_q;
        end
    end

    assign dq_out = half ? dq_n : dq_q;
    assign dq_oe = half ? oe_n : rd_oe;
    assign dqs_out = half ? dqs_n : dqs_q;
    assign dqs_oe = half ? oe_n : rd_oe;

    // Write elements are taken on each strobe change while room remains.
    assign wcol = elem_col(wr_col, wr_idx, mask, cfg_q2.itl);
    assign wr_take = wr_active && (dqs_in != dqs_prev) && fifo_ready
                     && !is_write && !is_read;
    assign wr_done = wr_take && wr_idx == mask;
    assign push_data = '{bank: wr_bank, col: wcol, data: dq_in};

    always_ff @(posedge link_ck) begin
        if (!link_rst_b) begin
            dqs_prev <= 1'b0;
        end else if (link_en) begin
            dqs_prev <= dqs_in;
        end
    end

    always_ff @(posedge link_ck) begin
        if (!link_rst_b) begin
            wr_active <= 1'b0;
            wr_ap <= 1'b0;
            wr_idx <= '0;
            wr_bank <= '0;
            wr_col <= '0;
        end else if (link_en) begin
            if (is_write) begin
                wr_active <= 1'b1;
                wr_idx <= '0;
                wr_bank <= link_bank;
                wr_col <= link_addr[DBS_COL_W-1:0];
                wr_ap <= link_addr[DBS_AP_BIT];
            end else if (is_read) begin
                wr_active <= 1'b0;
            end else if (wr_take) begin
                wr_idx <= wr_idx + 3'h1;
                wr_active <= wr_idx != mask;
            end
        end
    end

    always_ff @(posedge link_ck) begin
        if (link_en && wr_take) begin
            mem[{wr_bank, wcol}] <= dq_in;
        end
    end

    // Rows open on activate and close on precharge or auto precharge.
    always_comb begin
        next_open = bank_open;
        for (int b = 0; b < DBS_NBANK; b++) begin
            if (is_act && link_bank == b[DBS_BANK_W-1:0]) begin
                next_open[b] = 1'b1;
            end
            if (is_pre && (link_addr[DBS_AP_BIT]
                           || link_bank == b[DBS_BANK_W-1:0])) begin
                next_open[b] = 1'b0;
            end
            if (wr_done && wr_ap && wr_bank == b[DBS_BANK_W-1:0]) begin
                next_open[b] = 1'b0;
            end
            if (rd_done && rd_ap && rd_bank == b[DBS_BANK_W-1:0]) begin
                next_open[b] = 1'b0;
            end
        end
    end

    always_ff @(posedge link_ck) begin
        if (!link_rst_b) begin
            bank_open <= '0;
        end else if (link_en) begin
            bank_open <= next_open;
        end
    end

    dbs_async_fifo #(
        .WIDTH($bits(dbs_wlog_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_wlog (
        .wclk(link_ck),
        .wrst_b(link_rst_b),
        .wen(link_en),
        .w_valid(wr_take),
        .w_ready(fifo_ready),
        .w_data(push_data),
        .rclk(ref_clk),
        .rrst_b(rst_b),
        .ren(clk_en),
        .r_valid(wlog_valid),
        .r_ready(wlog_ready),
        .r_data(wlog_data)
    );

    // Link status returns to the core domain.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            open_q1 <= '0;
            open_q2 <= '0;
            busy_q1 <= 1'b0;
            link_busy <= 1'b0;
        end else if (clk_en) begin
            open_q1 <= bank_open;
            open_q2 <= open_q1;
            busy_q1 <= rd_oe | wr_active;
            link_busy <= busy_q1;
        end
    end

    assign bank_open_sts = open_q2;

    a_cl_three: assert property (
        @(posedge link_ck) disable iff (!link_rst_b)
        (is_read && cfg_q2.cl == DBS_CL_3 && link_en) |-> ##4 rd_oe)
        else $error("Read at latency three did not drive on time.");

    a_cl_two: assert property (
        @(posedge link_ck) disable iff (!link_rst_b)
        (is_read && cfg_q2.cl != DBS_CL_3) ##1 link_en[*2]
        |-> ##1 (rd_oe && rd_idx == 3'h1))
        else $error("First read element not at latency two.");

    a_dqs_edge_each: assert property (
        @(posedge link_ck) disable iff (!link_rst_b)
        (link_en && rd_oe && $past(rd_oe) && $past(link_en))
        |-> dqs_q != $past(dqs_q))
        else $error("Strobe did not toggle with a read element.");

    a_bl4_concat: assert property (
        @(posedge link_ck) disable iff (!link_rst_b)
        (is_read && cfg_q2.bl == DBS_BL_4 && cfg_q2.cl != DBS_CL_3)
        ##4 is_read ##1 link_en[*3] |-> rd_oe)
        else $error("Burst of four reads did not concatenate.");

    a_read_cut: assert property (
        @(posedge link_ck) disable iff (!link_rst_b)
        (is_read && cfg_q2.bl == DBS_BL_8 && cfg_q2.cl != DBS_CL_3)
        ##1 link_en ##1 is_read ##1 link_en[*2] |-> ##1 rd_idx == 3'h1)
        else $error("Second read did not truncate the first.");

    a_bst_stop: assert property (
        @(posedge link_ck) disable iff (!link_rst_b)
        is_bst ##1 (link_en && !is_read)[*3] |-> ##1 !rd_oe)
        else $error("Burst terminate did not stop read data.");

    a_row_kept_open: assert property (
        @(posedge link_ck) disable iff (!link_rst_b)
        (link_en && wr_done && !wr_ap && !is_pre)
        |=> bank_open[$past(wr_bank)] == $past(bank_open[wr_bank]))
        else $error("Write without auto precharge closed its row.");

    a_write_restart: assert property (
        @(posedge link_ck) disable iff (!link_rst_b)
        is_write |=> (wr_active && wr_idx == 3'h0))
        else $error("New write did not restart the write burst.");

    a_read_ends_write: assert property (
        @(posedge link_ck) disable iff (!link_rst_b)
        (is_read && !is_write) |=> !wr_active ##1 !$past(wr_take))
        else $error("Read did not end the write burst.");
endmodule // dbs_ddr_sequencer
`default_nettype wire

// File: sim/dbs_ctrl_model.sv
// Memory controller model that drives the link side of the sequencer.
`default_nettype none
module dbs_ctrl_model import dbs_pkg::*; (
    input wire logic link_ck,
    output dbs_cmd_t link_cmd,
    output logic [DBS_BANK_W-1:0] link_bank,
    output logic [DBS_ADDR_W-1:0] link_addr,
    output logic [DBS_DQ_W-1:0] dq_drv,
    output logic dqs_drv,
    output int edge_no
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        link_cmd = DBS_CMD_NOP;
        link_bank = '0;
        link_addr = '0;
        dq_drv = '0;
        dqs_drv = 1'b0;
    end

    always @(posedge link_ck) begin
        edge_no <= edge_no + 1;
    end

    // One link cycle; e is the link edge that samples what is driven here.
    task automatic step(input logic [3:0] c, input logic [1:0] b,
                        input logic [12:0] a, input logic w,
                        input logic [15:0] d, output int e);
        @(posedge link_ck);
        e = edge_no + 2;
        link_cmd <= c;
        link_bank <= b;
        link_addr <= a;
        // Released data lines show the inverse of the last value.
        dq_drv <= w ? d : ~dq_drv;
        if (w) begin
            dqs_drv <= ~dqs_drv;
        end
    endtask
endmodule // dbs_ctrl_model
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the burst sequencer with its write log.
`default_nettype none
module testbench import dbs_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_b, clk_en, cfg_interleave, link_ck, dqs_drv, wlog_ready;
    logic [1:0] cfg_cas_latency, cfg_burst_length;
    dbs_cmd_t link_cmd;
    logic [1:0] link_bank;
    logic [12:0] link_addr;
    logic [15:0] dq_drv, dq_out, dq_w;
    logic dq_oe, dqs_out, dqs_oe, dqs_w, wlog_valid, link_busy;
    dbs_wlog_t wlog_data;
    logic [3:0] bank_open_sts;
    int e_no, num_errors, num_checks;
    logic [15:0] mem [4][16];
    logic [15:0] cap_dq [1024], ex_dq [1024];
    logic [1:0] cap_ox [1024], ex_ox [1024];
    bit ex_use [1024];
    dbs_wlog_t wq [$], got [$];

    assign dq_w = dq_oe ? dq_out : dq_drv;
    assign dqs_w = dqs_oe ? dqs_out : dqs_drv;

    dbs_ctrl_model ctl_u (.link_ck(link_ck), .link_cmd(link_cmd),
        .link_bank(link_bank), .link_addr(link_addr), .dq_drv(dq_drv),
        .dqs_drv(dqs_drv), .edge_no(e_no));

    dbs_ddr_sequencer dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
        .clk_en(clk_en), .cfg_cas_latency(cfg_cas_latency),
        .cfg_burst_length(cfg_burst_length),
        .cfg_interleave(cfg_interleave), .link_ck(link_ck),
        .link_cmd(link_cmd), .link_bank(link_bank), .link_addr(link_addr),
        .dq_in(dq_w), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_w),
        .dqs_out(dqs_out), .dqs_oe(dqs_oe), .wlog_valid(wlog_valid),
        .wlog_ready(wlog_ready), .wlog_data(wlog_data),
        .bank_open_sts(bank_open_sts), .link_busy(link_busy));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        link_ck = 1'b0;
        #3;
        forever #80 link_ck = ~link_ck;
    end

    always @(posedge link_ck) begin
        cap_dq[(e_no + 1) % 1024] <= dq_out;
        cap_ox[(e_no + 1) % 1024] <= {dq_oe, dqs_out};
    end
    always @(posedge ref_clk) begin
        wlog_ready <= 1'($urandom);
        if (wlog_valid === 1'b1 && wlog_ready === 1'b1) begin
            got.push_back(wlog_data);
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic logic [3:0] col_at(input logic [3:0] s, input int i);
        logic [3:0] m;
        m = 4'((1 << cfg_burst_length) - 1);
        if (cfg_interleave) begin
            return (s & ~m) | ((s ^ 4'(i)) & m);
        end
        return (s & ~m) | ((s + 4'(i)) & m);
    endfunction

    task automatic idle(input int n);
        int e;
        repeat (n) ctl_u.step(DBS_CMD_NOP, 2'h0, 13'h0, 1'b0, 16'h0, e);
    endtask

    task automatic set_cfg(input logic [1:0] cl, input logic [1:0] bl,
                           input logic itl);
        @(posedge ref_clk);
        cfg_cas_latency <= cl;
        cfg_burst_length <= bl;
        cfg_interleave <= itl;
        idle(4);
    endtask

    task automatic do_wr(input logic [1:0] b, input logic [3:0] s,
                         input int n);
        int e;
        logic [15:0] d;
        logic [3:0] c;
        ctl_u.step(DBS_CMD_WRITE, b, 13'(s), 1'b0, 16'h0, e);
        for (int i = 0; i < n; i++) begin
            d = 16'($urandom);
            c = col_at(s, i);
            ctl_u.step(DBS_CMD_NOP, b, 13'h0, 1'b1, d, e);
            mem[b][c] = d;
            wq.push_back({b, c, d});
        end
    endtask

    // Expected pin activity of a read whose command is sampled at edge e.
    task automatic do_rd(input logic [1:0] b, input logic [3:0] s,
                         input int n);
        int e, t;
        ctl_u.step(DBS_CMD_READ, b, 13'(s), 1'b0, 16'h0, e);
        t = e + ((cfg_cas_latency == DBS_CL_3) ? 4 : 3);
        for (int i = 0; i <= n; i++) begin
            ex_dq[(t + i) % 1024] = (i < n) ? mem[b][col_at(s, i)] : 16'h0;
            ex_ox[(t + i) % 1024] = (i < n) ? {1'b1, ~i[0]} : 2'h0;
            ex_use[(t + i) % 1024] = 1'b1;
        end
    endtask

    task automatic chk_pins();
        idle(14);
        for (int e = 0; e < 1024; e++) begin
            if (ex_use[e]) begin
                check({cap_ox[e], ex_ox[e][1] ? cap_dq[e] : 16'h0},
                      {ex_ox[e], ex_ox[e][1] ? ex_dq[e] : 16'h0});
                ex_use[e] = 1'b0;
            end
        end
    endtask

    initial begin
        logic [1:0] b;
        logic [3:0] s;
        int e;
        void'($urandom(32'h4726302A));
        rst_b = 1'b0;
        clk_en = 1'b1;
        cfg_cas_latency = DBS_CL_RST;
        cfg_burst_length = DBS_BL_RST;
        cfg_interleave = DBS_ITL_RST;
        num_errors = 0;
        num_checks = 0;
        repeat (5) @(posedge link_ck);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        idle(4);
        for (int i = 0; i < 4; i++) begin
            ctl_u.step(DBS_CMD_ACT, 2'(i), 13'h0, 1'b0, 16'h0, e);
        end
        idle(4);
        check(32'(bank_open_sts), 32'hF);
        set_cfg(DBS_CL_2, DBS_BL_8, 1'b0);
        for (int i = 0; i < 8; i++) begin
            do_wr(2'(i), 4'(i[2] * 8), 8);
        end
        for (int cl = 0; cl < 3; cl++) begin
            for (int bl = 1; bl < 4; bl++) begin
                set_cfg(2'(cl), 2'(bl), 1'($urandom));
                b = 2'($urandom);
                s = 4'($urandom);
                do_wr(b, s, 1 << bl);
                idle(2);
                do_rd(b, s, 1 << bl);
                idle(8);
                do_rd(b + 2'h1, 4'($urandom), 1 << bl);
                chk_pins();
            end
        end
        check(32'(bank_open_sts), 32'hF);
        for (int k = 0; k < 6; k++) begin
            set_cfg(2'(k % 3), 2'(2 + k / 3), 1'($urandom));
            do_rd(2'($urandom), 4'($urandom), 4 << (k / 3));
            idle(3);
            do_rd(2'($urandom), 4'($urandom), 4 << (k / 3));
            idle(8);
            do_rd(2'($urandom), 4'($urandom), 4 << (k / 3));
            idle(1);
            do_rd(2'($urandom), 4'($urandom), 4 << (k / 3));
            chk_pins();
        end
        b = 2'($urandom);
        s = 4'($urandom);
        do_rd(b, s, 4);
        idle(3);
        ctl_u.step(DBS_CMD_BST, b, 13'h0, 1'b0, 16'h0, e);
        chk_pins();
        do_wr(b, s, 2);
        idle(2);
        check(32'(link_busy), 32'h1);
        do_rd(b, s, 8);
        chk_pins();
        check(32'(link_busy), 32'h0);
        do_wr(b, s, 2);
        do_wr(b, s + 4'h5, 8);
        idle(2);
        do_rd(b, s, 8);
        idle(8);
        do_rd(b, s + 4'h5, 8);
        chk_pins();
        ctl_u.step(DBS_CMD_PRE, 2'h0, 13'h400, 1'b0, 16'h0, e);
        idle(4);
        check(32'(bank_open_sts), 32'h0);
        repeat (300) @(posedge ref_clk);
        check(32'(got.size()), 32'(wq.size()));
        for (int i = 0; i < wq.size() && i < got.size(); i++) begin
            check(32'(got[i]), 32'(wq[i]));
        end
        report_and_stop();
    end

    initial begin
        #800us;
        num_errors++;
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
